//--- hdl/wtc_recorder.v
// waveform trace recorder with wishbone register slave
// Operation
// R1 - sample holds nine analogs, relays, contacts
// R2 - trace data kept only in volatile ram
// R3 - partitions 2x2048, 4x1024, 8x512, 16x256
// R4 - first factor buffers, second samples each
// R5 - sixteen samples per power cycle
// R6 - buffers form ring, oldest overwritten
// R7 - one buffer always free for next capture
// R8 - partition change erases all trace data
// R9 - trigger position sets pre-trigger share
// R10 - pickup trigger enable
// R11 - dropout trigger enable
// R12 - trip trigger enable
// R13 - alarm trigger enable
// R14 - fill after trigger, then advance buffer
// R15 - triggers ored, ignored during post fill
`default_nettype none
`include "wtc_defs.vh"

module wtc_recorder (
   // clock and reset
   input  wire                                    clk_i,
   input  wire                                    rst_i,
   // wishbone slave
   input  wire                                    wb_cyc_i,
   input  wire                                    wb_stb_i,
   input  wire                                    wb_we_i,
   input  wire [7:0]                              wb_adr_i,
   input  wire [3:0]                              wb_sel_i,
   input  wire [31:0]                             wb_dat_i,
   output reg  [31:0]                             wb_dat_o,
   output reg                                     wb_ack_o,
   // sampling front end
   input  wire                                    sample_stb_i,
   input  wire [`WTC_NUM_CH*`WTC_CH_W-1:0]         ch_data_i,
   input  wire [`WTC_RELAY_W-1:0]                 relay_state_i,
   input  wire [`WTC_CONTACT_W-1:0]               contact_state_i,
   // protection element events
   input  wire                                    pickup_evt_i,
   input  wire                                    dropout_evt_i,
   input  wire                                    trip_evt_i,
   input  wire                                    alarm_evt_i,
   // status
   output reg                                     post_fill_o,
   output reg                                     clearing_o
);

   // ****************************************
   // states
   // ****************************************
   localparam [1:0] ST_CLEAR = 2'h0;
   localparam [1:0] ST_PRE   = 2'h1;
   localparam [1:0] ST_POST  = 2'h2;

   // ****************************************
   // registers
   // ****************************************
   reg  [1:0]              buffer_partition_select;
   reg  [3:0]              trig_en;
   reg  [6:0]              trig_pos;
   reg  [`WTC_ADDR_W-1:0]  rd_addr;
   reg  [`WTC_ADDR_W-1:0]  last_start;
   reg  [1:0]              state;
   reg  [`WTC_ADDR_W-1:0]  clr_addr;
   reg  [`WTC_ADDR_W-1:0]  wr_off;
   reg  [`WTC_ADDR_W-1:0]  fill;
   reg  [`WTC_ADDR_W-1:0]  post_left;
   reg  [3:0]              buf_idx;
   reg  [4:0]              stored;
   reg  [1:0]              next_state;

   // ****************************************
   // geometry
   // ****************************************
   // partition code n gives 2<<n buffers of 2048>>n samples
   wire [`WTC_ADDR_W-1:0] buf_len  = `WTC_MAX_LEN >> buffer_partition_select; // R3
   wire [4:0]             buf_num  = 5'h02 << buffer_partition_select; // R4
   wire [3:0]             buf_mask = buf_num[3:0] - 4'h1;
   wire [`WTC_ADDR_W-1:0] off_mask = buf_len - 12'h001;
   wire [`WTC_ADDR_W-1:0] buf_base = {buf_idx, 8'h00} << (2'h3 - buffer_partition_select); // R4

   // pre-trigger share, truncated to whole samples
   wire [18:0] pos_ext  = {12'h000, trig_pos};
   wire [18:0] len_ext  = {7'h00, buf_len};
   wire [18:0] pre_prod = pos_ext * len_ext; // R9
   wire [18:0] pre_div  = pre_prod / `WTC_PERCENT; // R9
   wire [`WTC_ADDR_W-1:0] pre_count = pre_div[`WTC_ADDR_W-1:0];
   wire [`WTC_ADDR_W-1:0] post_len  = buf_len - pre_count;

   // ****************************************
   // sample assembly and trigger
   // ****************************************
   // one strobe per sixteenth of a power cycle from the front end
   wire [`WTC_SAMPLE_W-1:0] sample = {contact_state_i, relay_state_i, ch_data_i}; // R1
   wire sample_take = sample_stb_i & (state != ST_CLEAR); // R5

   wire trig_pickup  = trig_en[`WTC_EN_PICKUP]  & pickup_evt_i;  // R10
   wire trig_dropout = trig_en[`WTC_EN_DROPOUT] & dropout_evt_i; // R11
   wire trig_trip    = trig_en[`WTC_EN_TRIP]    & trip_evt_i;    // R12
   wire trig_alarm   = trig_en[`WTC_EN_ALARM]   & alarm_evt_i;   // R13
   // trigger only honoured while gathering pre-trigger data
   wire trig = (state == ST_PRE) & (trig_pickup | trig_dropout | trig_trip | trig_alarm); // R15

   // next write position within the buffer, wrapping during pre-trigger
   wire [`WTC_ADDR_W-1:0] off_inc  = (wr_off + 12'h001) & off_mask;
   wire [`WTC_ADDR_W-1:0] off_nxt  = sample_take ? off_inc : wr_off;
   wire [`WTC_ADDR_W-1:0] fill_nxt = (sample_take && fill != buf_len) ? fill + 12'h001 : fill;
   wire [`WTC_ADDR_W-1:0] cap_start = (fill_nxt == buf_len) ? off_nxt : 12'h000;

   // capture ends on last post sample, or at once when no post share
   wire done_post = (state == ST_POST) & sample_take & (post_left == 12'h001); // R14
   wire done_now  = trig & (post_len == 12'h000);
   wire advance   = done_post | done_now;

   // ****************************************
   // bus decode
   // ****************************************
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire bus_wr  = bus_req & wb_we_i;
   wire wr_ctrl = bus_wr & (wb_adr_i == `WTC_OFS_CTRL);
   wire [1:0] part_new = wb_dat_i[`WTC_CTRL_PART_LSB +: 2];
   // any change of partitioning wipes the store
   wire part_chg = wr_ctrl & wb_sel_i[0] & (part_new != buffer_partition_select); // R8

   // ****************************************
   // storage
   // ****************************************
   wire                     ram_we    = (state == ST_CLEAR) | sample_take;
   wire [`WTC_ADDR_W-1:0]   ram_waddr = (state == ST_CLEAR) ? clr_addr : (buf_base | wr_off);
   wire [`WTC_SAMPLE_W-1:0] ram_wdata = (state == ST_CLEAR) ? {`WTC_SAMPLE_W{1'b0}} : sample;
   wire [`WTC_SAMPLE_W-1:0] rd_sample;

   wtc_trace_ram u_ram (
      .clk_i     (clk_i),
      .wr_en_i   (ram_we),
      .wr_addr_i (ram_waddr),
      .wr_data_i (ram_wdata),
      .rd_addr_i (rd_addr),
      .rd_data_o (rd_sample)
   );

   // ****************************************
   // state machine
   // ****************************************
   always @* begin
      next_state = state;
      case (state)
         ST_CLEAR: begin
            if (clr_addr == 12'hFFF) begin
               next_state = ST_PRE;
            end
         end
         ST_PRE: begin
            if (trig && !done_now) begin
               next_state = ST_POST; // R14
            end
         end
         ST_POST: begin
            if (done_post) begin
               next_state = ST_PRE; // R14
            end
         end
         default: begin
            next_state = ST_CLEAR;
         end
      endcase
      if (part_chg) begin
         next_state = ST_CLEAR; // R8
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state      <= ST_CLEAR;
         clr_addr   <= 12'h000;
         wr_off     <= 12'h000;
         fill       <= 12'h000;
         post_left  <= 12'h000;
         buf_idx    <= 4'h0;
         stored     <= 5'h00;
         last_start <= 12'h000;
      end else begin
         state <= next_state;
         if (part_chg || state == ST_CLEAR) begin
            // erase pointers, counts and contents together
            clr_addr  <= part_chg ? 12'h000 : clr_addr + 12'h001; // R8
            wr_off    <= 12'h000;
            fill      <= 12'h000;
            post_left <= 12'h000;
            buf_idx   <= 4'h0;
            stored    <= 5'h00; // R8
         end else if (advance) begin
            last_start <= buf_base | cap_start;
            buf_idx    <= (buf_idx + 4'h1) & buf_mask; // R6
            wr_off     <= 12'h000;
            fill       <= 12'h000;
            // ring keeps one buffer free, so retained is one short
            if (stored < {1'b0, buf_mask}) begin
               stored <= stored + 5'h01; // R7
            end
         end else begin
            wr_off <= off_nxt;
            fill   <= fill_nxt;
            if (trig) begin
               post_left <= post_len; // R9
            end else if (state == ST_POST && sample_take) begin
               post_left <= post_left - 12'h001; // R14
            end
         end
      end
   end

   // ****************************************
   // register writes
   // ****************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         buffer_partition_select <= `WTC_PART_RST;
         trig_en                 <= `WTC_EN_RST;
         trig_pos                <= `WTC_POS_RST;
         rd_addr                 <= 12'h000;
      end else begin
         if (wr_ctrl && wb_sel_i[0]) begin
            buffer_partition_select <= part_new; // R3
         end
         if (wr_ctrl && wb_sel_i[1]) begin
            trig_en <= wb_dat_i[`WTC_CTRL_EN_LSB +: 4];
         end
         if (wr_ctrl && wb_sel_i[2]) begin
            // out of range share clamps to the whole buffer
            trig_pos <= (wb_dat_i[`WTC_CTRL_POS_LSB +: 7] > `WTC_POS_MAX) ?
                        `WTC_POS_MAX : wb_dat_i[`WTC_CTRL_POS_LSB +: 7]; // R9
         end
         if (bus_wr && wb_adr_i == `WTC_OFS_RDADDR) begin
            if (wb_sel_i[0]) begin
               rd_addr[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               rd_addr[11:8] <= wb_dat_i[11:8];
            end
         end
      end
   end

   // ****************************************
   // register reads and ack
   // ****************************************
   wire [191:0] rd_pad  = {24'h000000, rd_sample};
   wire [7:0]   dat_sel = wb_adr_i - `WTC_OFS_DATA0;
   reg  [31:0]  next_dat;

   always @* begin
      next_dat = 32'h00000000;
      case (wb_adr_i)
         `WTC_OFS_CTRL: begin
            next_dat[`WTC_CTRL_PART_LSB +: 2] = buffer_partition_select;
            next_dat[`WTC_CTRL_EN_LSB +: 4]   = trig_en;
            next_dat[`WTC_CTRL_POS_LSB +: 7]  = trig_pos;
         end
         `WTC_OFS_STATUS: begin
            next_dat[`WTC_STAT_STATE_LSB +: 2] = state;
            next_dat[`WTC_STAT_BUF_LSB +: 4]   = buf_idx;
            next_dat[`WTC_STAT_CNT_LSB +: 5]   = stored;
            next_dat[`WTC_STAT_PRE_LSB +: 12]  = pre_count;
         end
         `WTC_OFS_LAST: begin
            next_dat[11:0] = last_start;
         end
         `WTC_OFS_RDADDR: begin
            next_dat[11:0] = rd_addr;
         end
         default: begin
            if (wb_adr_i >= `WTC_OFS_DATA0 && wb_adr_i <= `WTC_OFS_DATA5 && wb_adr_i[1:0] == 2'h0) begin
               next_dat = rd_pad[dat_sel[4:2]*32 +: 32];
            end
         end
      endcase
   end

   // ack one cycle after the request, unmapped reads give zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= 32'h00000000;
         post_fill_o <= 1'b0;
         clearing_o  <= 1'b1;
      end else begin
         wb_ack_o    <= bus_req;
         wb_dat_o    <= (bus_req && !wb_we_i) ? next_dat : 32'h00000000;
         post_fill_o <= (next_state == ST_POST);
         clearing_o  <= (next_state == ST_CLEAR);
      end
   end

endmodule // wtc_recorder
`default_nettype wire

//--- shared/wtc_defs.vh
// constants of the waveform trace capture block
`ifndef WTC_DEFS_VH
`define WTC_DEFS_VH

// ****************************************
// register word offsets (byte address)
// ****************************************
`define WTC_OFS_CTRL     8'h00
`define WTC_OFS_STATUS   8'h04
`define WTC_OFS_LAST     8'h08
`define WTC_OFS_RDADDR   8'h0C
`define WTC_OFS_DATA0    8'h10
`define WTC_OFS_DATA5    8'h24

// ****************************************
// control register fields
// ****************************************
`define WTC_CTRL_PART_LSB  0
`define WTC_CTRL_EN_LSB    8
`define WTC_CTRL_POS_LSB   16
`define WTC_PART_RST       2'h3
`define WTC_EN_RST         4'h5
`define WTC_POS_RST        7'h19
`define WTC_POS_MAX        7'h64

// ****************************************
// trigger enable bits
// ****************************************
`define WTC_EN_PICKUP   0
`define WTC_EN_DROPOUT  1
`define WTC_EN_TRIP     2
`define WTC_EN_ALARM    3

// ****************************************
// status register fields
// ****************************************
`define WTC_STAT_STATE_LSB  0
`define WTC_STAT_BUF_LSB    4
`define WTC_STAT_CNT_LSB    8
`define WTC_STAT_PRE_LSB    16

// ****************************************
// storage geometry
// ****************************************
`define WTC_CH_W        16
`define WTC_NUM_CH      9
`define WTC_RELAY_W     8
`define WTC_CONTACT_W   16
`define WTC_SAMPLE_W    168
`define WTC_ADDR_W      12
`define WTC_MEM_WORDS   4096
`define WTC_MAX_LEN     12'h800
`define WTC_PERCENT     19'h00064
`define WTC_SAMPLES_PER_CYCLE 16

`endif

//--- hdl/wtc_trace_ram.v
// volatile sample store with one write and one read port
`default_nettype none
`include "wtc_defs.vh"

module wtc_trace_ram (
   // clock
   input  wire                        clk_i,
   // write port
   input  wire                        wr_en_i,
   input  wire [`WTC_ADDR_W-1:0]      wr_addr_i,
   input  wire [`WTC_SAMPLE_W-1:0]    wr_data_i,
   // read port
   input  wire [`WTC_ADDR_W-1:0]      rd_addr_i,
   output reg  [`WTC_SAMPLE_W-1:0]    rd_data_o
);

   // plain ram, no retention or backup path
   reg [`WTC_SAMPLE_W-1:0] mem [0:`WTC_MEM_WORDS-1]; // R2

   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule // wtc_trace_ram
`default_nettype wire

//--- verif/wtc_front_model.sv
// front end and event source model feeding the recorder
`default_nettype none
module wtc_front #(
   parameter int DIV = 4
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // bench controls
   input  wire logic [3:0]  evt_req_i,
   input  wire logic [7:0]  relay_i,
   input  wire logic [15:0] contact_i,
   // recorder side
   output logic             sample_stb_o,
   output logic [143:0]     ch_data_o,
   output logic [7:0]       relay_state_o,
   output logic [15:0]      contact_state_o,
   output logic [3:0]       evt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int          div_n;
   logic [11:0] seq;
   // strobe spacing shortened; the real rate is far slower
   always_ff @(posedge clk_i) begin
      evt_o <= rst_i ? 4'h0 : evt_req_i;
      div_n <= (rst_i || div_n == DIV - 1) ? 0 : div_n + 1;
      sample_stb_o <= !rst_i && div_n == DIV - 1;
      if (rst_i) seq <= 12'h0;
      else if (sample_stb_o) seq <= seq + 12'h1;
   end
   // channel number in the top nibble makes misplaced words visible
   always_comb begin
      for (int k = 0; k < 9; k++) ch_data_o[k*16 +: 16] = {4'(k), seq};
      relay_state_o = relay_i;
      contact_state_o = contact_i;
   end
endmodule // wtc_front
`default_nettype wire

//--- verif/wtc_recorder_monitor.sv
// port assertions for the trace recorder
`default_nettype none
module wtc_chk (
   // clock, reset, bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // capture side
   input wire logic        sample_stb_i,
   input wire logic        pickup_evt_i,
   input wire logic        dropout_evt_i,
   input wire logic        trip_evt_i,
   input wire logic        alarm_evt_i,
   input wire logic        post_fill_o,
   input wire logic        clearing_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   int unsigned clr_n;
   int unsigned stb_n;
   always_ff @(posedge clk_i) begin
      clr_n <= (rst_i || !clearing_o) ? 0 : clr_n + 1;
      stb_n <= (rst_i || !post_fill_o) ? 0 : stb_n + sample_stb_i;
   end
   chk_ack_single:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   chk_ack_next:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   chk_dat_idle:
      assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   chk_erase_len:
      assert property (clearing_o |-> clr_n <= 4097) else $error("erase too long");
   chk_erase_quiet:
      assert property (clearing_o |-> !post_fill_o) else $error("fill during erase");
   chk_trig_cause:
      assert property ($rose(post_fill_o) |-> ($past(pickup_evt_i) || $past(dropout_evt_i) ||
         $past(trip_evt_i) || $past(alarm_evt_i)) && !$past(clearing_o)) else $error("fill without trigger");
   chk_fill_end:
      assert property ($fell(post_fill_o) |-> $past(sample_stb_i) || clearing_o) else $error("fill ended early");
   chk_fill_cap:
      assert property (post_fill_o |-> stb_n <= 2048) else $error("fill overruns buffer");
endmodule // wtc_chk
bind wtc_recorder wtc_chk mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_stb_i(sample_stb_i), .pickup_evt_i(pickup_evt_i),
   .dropout_evt_i(dropout_evt_i), .trip_evt_i(trip_evt_i), .alarm_evt_i(alarm_evt_i),
   .post_fill_o(post_fill_o), .clearing_o(clearing_o));
`default_nettype wire

//--- verif/wtc_recorder_test.sv
// self-checking bench for the trace recorder
`default_nettype none
module wtc_recorder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, relay_v = 8'h00, relay;
   logic [15:0] contact_v = 16'h0000, contact;
   logic [31:0] wdat = 32'h0, wb_dat_o, q, d0;
   logic [3:0] req = 4'h0, evt, sel = 4'hF, sel_v = 4'hF;
   logic [143:0] ch_data;
   logic wb_ack_o, sample_stb, post_fill_o, clearing_o;
   int seed = 32'hA9572E07;
   int err_total = 0, compares = 0, cyc_n = 0, n, pos;
   always #4 clk_i = ~clk_i;
   wtc_front #(.DIV(4)) front (.clk_i(clk_i), .rst_i(rst_i), .evt_req_i(req), .relay_i(relay_v),
      .contact_i(contact_v), .sample_stb_o(sample_stb), .ch_data_o(ch_data), .relay_state_o(relay),
      .contact_state_o(contact), .evt_o(evt));
   wtc_recorder uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .sample_stb_i(sample_stb), .ch_data_i(ch_data), .relay_state_i(relay), .contact_state_i(contact),
      .pickup_evt_i(evt[0]), .dropout_evt_i(evt[1]), .trip_evt_i(evt[2]), .alarm_evt_i(evt[3]),
      .post_fill_o(post_fill_o), .clearing_o(clearing_o));
   // ****
   // helpers
   // ****
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= dv;
      sel <= sel_v;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      r = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 20) chk(32'h0, 32'h1, "no ack");
   endtask
   task automatic wait_idle();
      int k;
      for (k = 0; k < 5000 && clearing_o !== 1'b0; k++) @(posedge clk_i);
      if (k == 5000) chk(32'h0, 32'h1, "erase hang");
   endtask
   // pulse sources, pulse again on the first fill cycle, count post samples
   task automatic cap(input logic [3:0] m, output int cnt);
      int k;
      cnt = 0;
      @(posedge clk_i);
      req <= m;
      @(posedge clk_i);
      req <= 4'h0;
      for (k = 0; k < 8 && post_fill_o !== 1'b1; k++) @(posedge clk_i);
      if (post_fill_o === 1'b1) req <= m;
      while (post_fill_o === 1'b1 && k < 12000) begin
         if (sample_stb === 1'b1) cnt++;
         @(posedge clk_i);
         req <= 4'h0;
         k++;
      end
   endtask
   function automatic int plen(int p, int ps);
      return (2048 >> p) - ps * (2048 >> p) / 100;
   endfunction
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 95000) begin
         err_total++;
         $display("BAD %0t timeout", $time);
         finish_test();
      end
   end
   // ****
   // scenarios
   // ****
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      relay_v <= 8'($random(seed));
      contact_v <= 16'($random(seed));
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h00190503, "ctrl reset");
      wb(1'b0, 8'h30, 32'h0, q);
      chk(q, 32'h0, "unmapped read");
      wait_idle();
      for (int s = 0; s < 4; s++) begin
         wb(1'b1, 8'h00, 32'h00320003 | (32'h100 << s), q);
         cap(4'hF & ~(4'h1 << s), n);
         chk(n, 0, "masked source");
         cap(4'h1 << s, n);
         chk(n, 128, "enabled source");
      end
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q & 32'h1FF3, 32'h0441, "status after masks");
      $display("trigger enable test done");
      for (int i = 0; i < 13; i++) begin
         pos = $unsigned($random(seed)) % 100;
         wb(1'b1, 8'h00, (32'(pos) << 16) | 32'h0F03, q);
         if (i == 12) repeat (1100) @(posedge clk_i);
         cap(4'h1 << (i % 4), n);
         chk(n, plen(3, pos), "post length");
      end
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q & 32'h1FF3, 32'h0F11, "ring status");
      wb(1'b0, 8'h08, 32'h0, q);
      chk(q & 32'hF00, 32'h0, "newest in buffer zero");
      wb(1'b1, 8'h0C, q, d0);
      wb(1'b0, 8'h10, 32'h0, d0);
      chk(d0[31:12], {4'h1, d0[11:0], 4'h0}, "data word zero");
      wb(1'b0, 8'h20, 32'h0, q);
      chk(q, {contact_v[7:0], relay_v, 4'h8, d0[11:0]}, "data word four");
      wb(1'b0, 8'h24, 32'h0, q);
      chk(q, {24'h0, contact_v[15:8]}, "data word five");
      $display("ring and readback test done");
      // corner: byte lane masks the partition, share over range clamps to all pre
      sel_v = 4'hE;
      wb(1'b1, 8'h00, 32'h007F0F00, q);
      sel_v = 4'hF;
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h00640F03, "masked partition and clamp");
      chk(clearing_o, 1'b0, "no erase without change");
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q & 32'h0FFF1FF3, 32'h01000F11, "full pre share");
      cap(4'h4, n);
      chk(n, 0, "no post fill at full share");
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q & 32'h1FF3, 32'h0F21, "advance at trigger");
      wb(1'b0, 8'h08, 32'h0, q);
      chk(q, 32'h00000100, "newest in buffer one");
      $display("corner test done");
      for (int p = 0; p < 3; p++) begin
         pos = $unsigned($random(seed)) % 100;
         wb(1'b1, 8'h00, (32'(pos) << 16) | 32'h0F00 | 32'(p), q);
         repeat (2) @(posedge clk_i);
         chk(clearing_o, 1'b1, "erase on change");
         wb(1'b0, 8'h04, 32'h0, q);
         chk(q & 32'h1F03, 32'h0, "erased status");
         wait_idle();
         repeat (2) begin
            cap(4'h1, n);
            chk(n, plen(p, pos), "partition length");
         end
         wb(1'b0, 8'h04, 32'h0, q);
         chk(q & 32'h1FF3, (p == 0) ? 32'h0101 : 32'h0221, "partition status");
      end
      $display("partition test done");
      // reset in mid-run restarts the erase and restores the settings
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({post_fill_o, clearing_o}, 2'h1, "outputs in reset");
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h00190503, "ctrl after reset");
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q & 32'h1FF3, 32'h0, "status after reset");
      $display("reset test done");
      finish_test();
   end
endmodule // wtc_recorder_test
`default_nettype wire
